// ==== rtl/spi_bridge_pkg.sv ====
// Constants and types shared by the isolated SPI bridge port control block
package spi_bridge_pkg;

	localparam int  CORE_MHZ          = 100;

	// Pulse half widths, ns
	localparam int  LONG_HALF_NS      = 150;
	localparam int  SHORT_HALF_NS     = 50;
	localparam int  LONG_HALF_CYC     = (LONG_HALF_NS * CORE_MHZ + 999) / 1000;
	localparam int  SHORT_HALF_CYC    = (SHORT_HALF_NS * CORE_MHZ + 999) / 1000;

	// Receive discrimination thresholds, ns
	localparam int  RX_LONG_MIN_NS    = 100;
	localparam int  RX_MIN_NS         = 20;
	localparam int  RX_LONG_MIN_CYC   = (RX_LONG_MIN_NS * CORE_MHZ + 999) / 1000;
	localparam int  RX_MIN_CYC        = (RX_MIN_NS * CORE_MHZ + 999) / 1000;

	// Slave side SCK pulse width, ns
	localparam int  SCK_PULSE_NS      = 115;
	localparam int  SCK_PULSE_SLOW_NS = 1100;
	localparam int  SCK_PULSE_CYC     = (SCK_PULSE_NS * CORE_MHZ + 999) / 1000;
	localparam int  SCK_SLOW_CYC      = (SCK_PULSE_SLOW_NS * CORE_MHZ + 999) / 1000;

	// Idle entry timeout
	localparam real IDLE_TIMEOUT_MS   = 5.7;
	localparam int  IDLE_TIMEOUT_CYC  = int'(IDLE_TIMEOUT_MS * 1000.0 * CORE_MHZ);

	// Register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam int         CTRL_FORCE    = 0;
	localparam int         ST_IDLE       = 0;
	localparam int         ST_OVF        = 1;
	localparam int         ST_ROLE       = 2;
	localparam int         ST_SLOW       = 3;
	localparam int         ST_POL        = 4;
	localparam int         ST_PHA        = 5;
	localparam logic       CTRL_FORCE_RST = 1'b0;

	localparam int  FIFO_DEPTH        = 8;

	// Edges after reset release until synchronised straps are valid
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef struct packed {
		logic long_p;
		logic plus;
	} pulse_t;

	typedef struct packed {
		logic role;
		logic slow;
		logic clock_idle_level_pin;
		logic clock_edge_select_pin;
	} strap_t;

	// Master side after reset: every SPI pin is an input
	localparam strap_t STRAP_RST = '{role: 1'b1, slow: 1'b0, clock_idle_level_pin: 1'b0, clock_edge_select_pin: 1'b0};

	typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} tx_state_t;
	typedef enum logic [1:0] {SL_IDLE, SL_SCK, SL_RET} sl_state_t;

endpackage

// ==== rtl/bit_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_q;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/pulse_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module pulse_fifo #(
	parameter int W     = 2,
	parameter int DEPTH = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = mem_q[rd_q];

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

`default_nettype wire

// ==== rtl/spi_bridge_port_ctl.sv ====
// Port role, pulse link and power state control of the isolated SPI bridge
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module spi_bridge_port_ctl
	import spi_bridge_pkg::*;
#(
	parameter int unsigned P_IDLE_CYC = IDLE_TIMEOUT_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic      [31:0] o_hrdata,
	input  wire logic        i_role_select,
	input  wire logic        i_reduced_rate_select,
	input  wire logic        i_clock_idle_level_pin,
	input  wire logic        i_clock_edge_select_pin,
	input  wire logic        i_enable,
	input  wire logic        i_mosi,
	output logic             o_mosi,
	output logic             o_mosi_oe,
	input  wire logic        i_miso,
	output logic             o_miso,
	output logic             o_miso_oe,
	input  wire logic        i_sck,
	output logic             o_sck,
	output logic             o_sck_oe,
	input  wire logic        i_cs,
	output logic             o_cs,
	output logic             o_cs_oe,
	input  wire logic        i_iso_line_positive,
	output logic             o_iso_line_positive,
	output logic             o_iso_line_positive_oe,
	input  wire logic        i_iso_line_negative,
	output logic             o_iso_line_negative,
	output logic             o_iso_line_negative_oe,
	output logic             o_idle
);

	// Synchronised pins
	logic [10:0] pins_sync;
	logic        s_mosi, s_miso, s_sck, s_cs, s_en, s_pos, s_neg;
	strap_t      s_strap;

	bit_sync #(.W(11)) u_sync (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_async    ({i_role_select, i_reduced_rate_select, i_clock_idle_level_pin,
		              i_clock_edge_select_pin, i_enable, i_mosi, i_miso, i_sck, i_cs,
		              i_iso_line_positive, i_iso_line_negative}),
		.o_sync     (pins_sync)
	);
	assign {s_strap, s_en, s_mosi, s_miso, s_sck, s_cs, s_pos, s_neg} = pins_sync;

	strap_t      strap_q;
	logic        init_q;
	logic [1:0]  init_cnt_q;
	logic        idle_q;
	logic        force_q;
	logic        ovf_q;
	logic [19:0] idle_cnt_q;
	logic        sck_prev_q, cs_prev_q;
	logic        miso_q, mosi_q, sck_q, cs_out_q;
	logic        en_act, quiet, wake;

	// Straps are frozen while active; capture waits out the synchroniser after reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			init_q     <= 1'b0;
			init_cnt_q <= '0;
			strap_q    <= STRAP_RST;
		end else begin
			if (init_cnt_q != STRAP_SETTLE) begin
				init_cnt_q <= init_cnt_q + 2'h1;
			end
			init_q <= (init_cnt_q == STRAP_SETTLE);
			if (!init_q || idle_q) begin
				strap_q <= s_strap;
			end
		end
	end

	// Receiver: level run-length discrimination of pulse pairs
	logic [1:0]  rx_lvl;
	logic [7:0]  rx_len_q;
	logic        rx_first_q, rx_plus_q, rx_second_q;
	logic        rx_evt;
	pulse_t      rx_code;
	logic        rx_act;
	logic        tx_busy;

	assign rx_lvl = tx_busy ? 2'h0 : {s_pos & ~s_neg, s_neg & ~s_pos};
	assign rx_act = (rx_lvl != 2'h0);
	assign rx_evt = rx_first_q && !rx_second_q && (rx_lvl == {~rx_plus_q, rx_plus_q})
	                && (rx_len_q >= 8'(RX_MIN_CYC));
	assign rx_code = '{long_p: (rx_len_q >= 8'(RX_LONG_MIN_CYC)), plus: rx_plus_q};

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_len_q    <= '0;
			rx_first_q  <= 1'b0;
			rx_plus_q   <= 1'b0;
			rx_second_q <= 1'b0;
		end else if (!rx_act) begin
			rx_first_q  <= 1'b0;
			rx_second_q <= 1'b0;
			rx_len_q    <= '0;
		end else if (!rx_first_q) begin
			rx_first_q <= 1'b1;
			rx_plus_q  <= rx_lvl[1];
			rx_len_q   <= 8'h01;
		end else if (rx_lvl != {rx_plus_q, ~rx_plus_q}) begin
			rx_second_q <= 1'b1;
		end else if (rx_len_q != 8'hFF) begin
			rx_len_q <= rx_len_q + 8'h01;
		end
	end

	// Master side event detection
	logic   cs_rise, cs_fall, sck_rise, sck_fall, latch;
	logic   m_evt;
	pulse_t m_code;

	assign cs_rise  = s_cs && !cs_prev_q;
	assign cs_fall  = !s_cs && cs_prev_q;
	assign sck_rise = s_sck && !sck_prev_q;
	assign sck_fall = !s_sck && sck_prev_q;
	assign latch    = !s_cs && ((strap_q.clock_idle_level_pin == strap_q.clock_edge_select_pin) ? sck_rise : sck_fall);
	// Pins read as 0 out of the synchroniser's reset; no false edges before init
	assign m_evt    = strap_q.role && init_q && (cs_rise || cs_fall || latch);
	assign m_code   = (cs_rise || cs_fall) ? '{long_p: 1'b1, plus: cs_rise}
	                                       : '{long_p: 1'b0, plus: s_mosi};

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cs_prev_q  <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_prev_q  <= s_cs;
			sck_prev_q <= s_sck;
		end
	end

	// MISO toward the controller: low after a returned -1, released per bit
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			miso_q <= 1'b1;
		end else if (strap_q.role && rx_evt && !rx_code.long_p && !rx_code.plus) begin
			miso_q <= 1'b0;
		end else if (cs_rise || latch) begin
			miso_q <= 1'b1;
		end
	end

	// Slave side: rebuild CS, MOSI and SCK, send return pulse
	sl_state_t  sl_st_q;
	logic [7:0] sl_cnt_q;
	logic       sl_push;
	logic       push_ready;

	assign sl_push = !strap_q.role && (sl_st_q == SL_RET) && !s_miso;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sl_st_q  <= SL_IDLE;
			sl_cnt_q <= '0;
			cs_out_q <= 1'b1;
			mosi_q   <= 1'b1;
			sck_q    <= 1'b0;
		end else if (strap_q.role) begin
			sl_st_q <= SL_IDLE;
			sck_q   <= strap_q.clock_idle_level_pin;
		end else begin
			unique case (sl_st_q)
				SL_IDLE: begin
					sck_q <= strap_q.clock_idle_level_pin;
					if (rx_evt && rx_code.long_p) begin
						cs_out_q <= rx_code.plus;
					end else if (rx_evt) begin
						mosi_q   <= rx_code.plus;
						sck_q    <= !strap_q.clock_idle_level_pin;
						sl_cnt_q <= strap_q.slow ? 8'(SCK_SLOW_CYC - 1) : 8'(SCK_PULSE_CYC - 1);
						sl_st_q  <= SL_SCK;
					end
				end
				SL_SCK: begin
					if (sl_cnt_q == 8'h00) begin
						sck_q   <= strap_q.clock_idle_level_pin;
						sl_st_q <= SL_RET;
					end else begin
						sl_cnt_q <= sl_cnt_q - 8'h01;
					end
				end
				SL_RET: begin
					if (s_miso || push_ready) begin
						sl_st_q <= SL_IDLE;
					end
				end
			endcase
		end
	end

	// Transmit queue and pulse pair generator
	pulse_t    push_code, f_data;
	logic      push_valid, f_valid, f_ready;
	tx_state_t tx_st_q;
	pulse_t    tx_cur_q;
	logic [7:0] tx_cnt_q;
	logic      tx_pos_q, tx_neg_q, tx_oe_q;

	assign push_valid = m_evt || sl_push;
	assign push_code  = strap_q.role ? m_code : '{long_p: 1'b0, plus: 1'b0};
	assign f_ready    = (tx_st_q == TX_IDLE);
	assign tx_busy    = (tx_st_q != TX_IDLE);

	pulse_fifo #(.W($bits(pulse_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_rstn      (i_rstn),
		.i_in_valid  (push_valid),
		.o_in_ready  (push_ready),
		.i_in_data   (push_code),
		.o_out_valid (f_valid),
		.i_out_ready (f_ready),
		.o_out_data  (f_data)
	);

	function automatic logic [7:0] half_cyc(input logic long_p);
		half_cyc = long_p ? 8'(LONG_HALF_CYC - 1) : 8'(SHORT_HALF_CYC - 1);
	endfunction

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_st_q  <= TX_IDLE;
			tx_cur_q <= '0;
			tx_cnt_q <= '0;
			tx_pos_q <= 1'b0;
			tx_neg_q <= 1'b0;
			tx_oe_q  <= 1'b0;
		end else begin
			unique case (tx_st_q)
				TX_IDLE: begin
					if (f_valid) begin
						tx_cur_q <= f_data;
						tx_cnt_q <= half_cyc(f_data.long_p);
						tx_pos_q <= f_data.plus;
						tx_neg_q <= !f_data.plus;
						tx_oe_q  <= 1'b1;
						tx_st_q  <= TX_FIRST;
					end
				end
				TX_FIRST: begin
					if (tx_cnt_q == 8'h00) begin
						tx_cnt_q <= half_cyc(tx_cur_q.long_p);
						tx_pos_q <= !tx_cur_q.plus;
						tx_neg_q <= tx_cur_q.plus;
						tx_st_q  <= TX_SECOND;
					end else begin
						tx_cnt_q <= tx_cnt_q - 8'h01;
					end
				end
				TX_SECOND: begin
					if (tx_cnt_q == 8'h00) begin
						tx_pos_q <= 1'b0;
						tx_neg_q <= 1'b0;
						tx_oe_q  <= 1'b0;
						tx_st_q  <= TX_IDLE;
					end else begin
						tx_cnt_q <= tx_cnt_q - 8'h01;
					end
				end
			endcase
		end
	end

	// Idle timer and wake-up
	assign en_act = s_en || force_q;
	assign quiet  = strap_q.role ? s_cs : !rx_act;
	assign wake   = strap_q.role ? cs_fall : rx_act;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			idle_cnt_q <= '0;
			idle_q     <= 1'b0;
		end else begin
			if (en_act || !quiet) begin
				idle_cnt_q <= '0;
			end else if (idle_cnt_q != 20'(P_IDLE_CYC)) begin
				idle_cnt_q <= idle_cnt_q + 20'h00001;
			end
			if (en_act) begin
				idle_q <= 1'b0;
			end else if (idle_q && wake) begin
				idle_q <= 1'b0;
			end else if (quiet && idle_cnt_q == 20'(P_IDLE_CYC - 1)) begin
				idle_q <= 1'b1;
			end
		end
	end

	// AHB-Lite register slave, zero wait states
	logic       ap_wr_q, ap_valid;
	logic [7:0] ap_addr_q;

	assign ap_valid    = i_hsel && i_htrans[1] && i_hready;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= '0;
			o_hrdata  <= '0;
		end else begin
			ap_wr_q   <= ap_valid && i_hwrite;
			ap_addr_q <= i_haddr[7:0];
			o_hrdata  <= '0;
			if (ap_valid && !i_hwrite && i_haddr[31:8] == 24'h000000) begin
				if (i_haddr[7:0] == REG_CTRL) begin
					o_hrdata[CTRL_FORCE] <= force_q;
				end else if (i_haddr[7:0] == REG_STATUS) begin
					o_hrdata[ST_IDLE] <= idle_q;
					o_hrdata[ST_OVF]  <= ovf_q;
					o_hrdata[ST_ROLE] <= strap_q.role;
					o_hrdata[ST_SLOW] <= strap_q.slow;
					o_hrdata[ST_POL]  <= strap_q.clock_idle_level_pin;
					o_hrdata[ST_PHA]  <= strap_q.clock_edge_select_pin;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			force_q <= CTRL_FORCE_RST;
			ovf_q   <= 1'b0;
		end else begin
			if (ap_wr_q && ap_addr_q == REG_CTRL) begin
				force_q <= i_hwdata[CTRL_FORCE];
			end
			if (m_evt && !push_ready) begin
				ovf_q <= 1'b1;
			end else if (ap_wr_q && ap_addr_q == REG_STATUS && i_hwdata[ST_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end

	// SPI pin directions follow the role strap; the pulse line enables follow tx_oe_q
	assign o_mosi                 = 1'b0;
	assign o_mosi_oe              = !strap_q.role && !mosi_q;
	assign o_miso                 = 1'b0;
	assign o_miso_oe              = strap_q.role && !miso_q;
	assign o_sck                  = sck_q;
	assign o_sck_oe               = !strap_q.role;
	assign o_cs                   = cs_out_q;
	assign o_cs_oe                = !strap_q.role;
	assign o_iso_line_positive    = tx_pos_q;
	assign o_iso_line_negative    = tx_neg_q;
	assign o_iso_line_positive_oe = tx_oe_q;
	assign o_iso_line_negative_oe = tx_oe_q;
	assign o_idle                 = idle_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_short_start;
		(tx_st_q == TX_IDLE) && f_valid && !f_data.long_p;
	endsequence
	sequence s_short_pair;
		(tx_st_q == TX_FIRST)[*5] ##1 (tx_st_q == TX_SECOND)[*5] ##1 (tx_st_q == TX_IDLE);
	endsequence

	AST_MOSI_IN: assert property (strap_q.role |-> !o_mosi_oe)
		else $error("MOSI driven in master role");
	AST_MISO_IN: assert property (!strap_q.role |-> !o_miso_oe)
		else $error("MISO driven in slave role");
	AST_SCK_DIR: assert property (o_sck_oe != strap_q.role)
		else $error("SCK direction wrong");
	AST_CS_DIR: assert property (o_cs_oe != strap_q.role)
		else $error("CS direction wrong");
	AST_NO_IDLE_EN: assert property (s_en |=> !idle_q)
		else $error("Idle while enabled");
	AST_IDLE_ENTRY: assert property ($rose(idle_q) |-> $past(quiet) && !$past(en_act)
		&& $past(idle_cnt_q) == 20'(P_IDLE_CYC - 1))
		else $error("Idle entered without full quiet time");
	AST_WAKE: assert property (idle_q && wake |=> !idle_q)
		else $error("No wake-up on trigger");
	AST_CS_PULSE: assert property (m_evt && (cs_rise || cs_fall) |->
		push_code.long_p && push_code.plus == cs_rise)
		else $error("Wrong pulse type for CS edge");
	AST_SHORT_PAIR: assert property (s_short_start |=> s_short_pair)
		else $error("Short pulse pair timing wrong");
	AST_SLAVE_CS: assert property (!strap_q.role && sl_st_q == SL_IDLE && rx_evt
		&& rx_code.long_p |=> cs_out_q == $past(rx_plus_q))
		else $error("CS not rebuilt from long pair");
	AST_STRAP_HOLD: assert property (init_q && !idle_q && !$past(idle_q) |-> $stable(strap_q))
		else $error("Strap changed while active");

endmodule

`default_nettype wire

// ==== tb/iso_peer.sv ====
// Far end of the isolated pulse link: sends pulse pairs and decodes arriving ones
`timescale 1ns/10ps
`default_nettype none
module iso_peer
	import spi_bridge_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_pos,
	input  wire logic i_neg,
	output logic      o_pos,
	output logic      o_neg,
	output logic      o_oe
);
	logic [1:0] lvl;
	logic [1:0] fst_q;
	logic       sec_q;
	int         n_q;
	int         rx_cnt;
	logic       got_long;
	logic       got_plus;

	assign lvl = {i_neg & ~i_pos, i_pos & ~i_neg};

	initial begin
		{o_pos, o_neg, o_oe, fst_q, sec_q} = '0;
		n_q = 0;
		rx_cnt = 0;
	end

	// Length of the first level tells long from short; own pulses are ignored
	always @(posedge i_core_clk) begin
		if (o_oe || lvl == 2'b00) begin
			fst_q <= 2'b00;
			sec_q <= 1'b0;
		end else if (fst_q == 2'b00) begin
			fst_q <= lvl;
			n_q <= 1;
		end else if (!sec_q && lvl == fst_q) begin
			n_q <= n_q + 1;
		end else if (!sec_q) begin
			sec_q <= 1'b1;
			got_long <= (n_q >= 10);
			got_plus <= (fst_q == 2'b01);
			rx_cnt <= rx_cnt + 1;
		end
	end

	// Symmetric pair, then both lines back to 0 V
	task automatic send_pair(input logic lng, input logic pls);
		int h;
		h = lng ? LONG_HALF_CYC : SHORT_HALF_CYC;
		@(posedge i_core_clk);
		o_oe <= 1'b1;
		o_pos <= pls;
		o_neg <= !pls;
		repeat (h) @(posedge i_core_clk);
		o_pos <= !pls;
		o_neg <= pls;
		repeat (h) @(posedge i_core_clk);
		{o_oe, o_pos, o_neg} <= 3'b000;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the bridge port control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk, rstn, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans;
	logic        role, enable, mosi_drv, miso_drv, sck_drv, cs_drv;
	logic        mosi_w, miso_w, sck_w, cs_w, pos_w, neg_w;
	logic        o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_sck, o_sck_oe, o_cs, o_cs_oe;
	logic        d_pos, d_neg, d_pos_oe, d_neg_oe, p_pos, p_neg, p_oe, o_idle;
	int          err_total, total_checks, cyc, c;

	// Released open-drain data lines take the bench drive; push-pull lines follow their driver
	assign mosi_w = o_mosi_oe ? o_mosi : mosi_drv;
	assign miso_w = o_miso_oe ? o_miso : miso_drv;
	assign sck_w = o_sck_oe ? o_sck : sck_drv;
	assign cs_w = o_cs_oe ? o_cs : cs_drv;
	assign pos_w = d_pos_oe ? d_pos : (p_oe & p_pos);
	assign neg_w = d_neg_oe ? d_neg : (p_oe & p_neg);

	spi_bridge_port_ctl #(.P_IDLE_CYC(200)) spi_bridge_port_ctl_inst (
		.i_core_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_role_select(role), .i_reduced_rate_select(1'b0),
		.i_clock_idle_level_pin(1'b0), .i_clock_edge_select_pin(1'b0), .i_enable(enable),
		.i_mosi(mosi_w), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
		.i_miso(miso_w), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
		.i_sck(sck_w), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
		.i_cs(cs_w), .o_cs(o_cs), .o_cs_oe(o_cs_oe),
		.i_iso_line_positive(pos_w), .o_iso_line_positive(d_pos),
		.o_iso_line_positive_oe(d_pos_oe), .i_iso_line_negative(neg_w),
		.o_iso_line_negative(d_neg), .o_iso_line_negative_oe(d_neg_oe), .o_idle(o_idle));

	iso_peer iso_peer_inst (.i_core_clk(clk), .i_pos(pos_w), .i_neg(neg_w),
		.o_pos(p_pos), .o_neg(p_neg), .o_oe(p_oe));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, wr};
		do @(posedge clk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
		do @(posedge clk); while (hready !== 1'b1);
		v = hrdata;
		chk(hresp, 1'b0);
	endtask

	// Straps change only while reset is held
	task automatic do_reset(input logic r);
		rstn <= 1'b0;
		role <= r;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
	endtask

	task automatic wait_rx(input int n0);
		for (int i = 0; i < 200 && iso_peer_inst.rx_cnt == n0; i++) @(negedge clk);
		chk(iso_peer_inst.rx_cnt, n0 + 1);
	endtask

	task automatic wait_idle(input logic lvl, input int lim);
		for (int i = 0; i < lim && o_idle !== lvl; i++) @(negedge clk);
		chk(o_idle, lvl);
	endtask

	task automatic chk_rx(input logic lng, input logic pls);
		wait_rx(c);
		chk(iso_peer_inst.got_long, lng);
		chk(iso_peer_inst.got_plus, pls);
		repeat (20) @(posedge clk);
	endtask

	task automatic sck_bit(input logic b);
		mosi_drv <= b;
		repeat (4) @(posedge clk);
		sck_drv <= 1'b1;
		c = iso_peer_inst.rx_cnt;
		chk_rx(1'b0, b);
		sck_drv <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_master_pins;
		@(negedge clk);
		chk({o_mosi_oe, o_sck_oe, o_cs_oe, o_miso_oe}, 4'h0);
		ahb(1'b0, 32'h04, 32'h0);
		chk(v, 32'h00000004);
		ahb(1'b1, 32'h00, 32'h00000001);
		ahb(1'b0, 32'h00, 32'h0);
		chk(v, 32'h00000001);
		ahb(1'b1, 32'h00, 32'h00000000);
		ahb(1'b0, 32'h08, 32'h0);
		chk(v, 32'h00000000);
		$display("master pins done");
	endtask

	task automatic t_master_link;
		c = iso_peer_inst.rx_cnt;
		cs_drv <= 1'b0;
		chk_rx(1'b1, 1'b0);
		sck_bit(1'b1);
		sck_bit(1'b0);
		iso_peer_inst.send_pair(1'b0, 1'b0);
		repeat (10) @(negedge clk);
		chk(o_miso_oe, 1'b1);
		chk(o_miso, 1'b0);
		c = iso_peer_inst.rx_cnt;
		cs_drv <= 1'b1;
		chk_rx(1'b1, 1'b1);
		chk(o_miso_oe, 1'b0);
		$display("master link done");
	endtask

	task automatic t_master_idle;
		cs_drv <= 1'b0;
		repeat (40) @(posedge clk);
		enable <= 1'b0;
		cs_drv <= 1'b1;
		repeat (180) @(negedge clk);
		chk(o_idle, 1'b0);
		wait_idle(1'b1, 50);
		cs_drv <= 1'b0;
		wait_idle(1'b0, 800);
		enable <= 1'b1;
		cs_drv <= 1'b1;
		repeat (400) @(negedge clk);
		chk(o_idle, 1'b0);
		$display("master idle done");
	endtask

	task automatic t_slave;
		do_reset(1'b0);
		@(negedge clk);
		chk({o_sck_oe, o_cs_oe, o_miso_oe}, 3'b110);
		iso_peer_inst.send_pair(1'b1, 1'b0);
		repeat (30) @(negedge clk);
		chk(o_cs, 1'b0);
		miso_drv <= 1'b0;
		c = iso_peer_inst.rx_cnt;
		iso_peer_inst.send_pair(1'b0, 1'b1);
		for (int i = 0; i < 30 && o_sck !== 1'b1; i++) @(negedge clk);
		chk(o_sck, 1'b1);
		chk(o_mosi_oe, 1'b0);
		wait_rx(c);
		chk({iso_peer_inst.got_long, iso_peer_inst.got_plus}, 2'b00);
		repeat (20) @(posedge clk);
		miso_drv <= 1'b1;
		c = iso_peer_inst.rx_cnt;
		iso_peer_inst.send_pair(1'b0, 1'b0);
		repeat (60) @(negedge clk);
		chk(o_mosi_oe, 1'b1);
		chk(o_mosi, 1'b0);
		chk(iso_peer_inst.rx_cnt, c);
		iso_peer_inst.send_pair(1'b1, 1'b1);
		repeat (30) @(negedge clk);
		chk(o_cs, 1'b1);
		enable <= 1'b0;
		repeat (150) @(negedge clk);
		chk(o_idle, 1'b0);
		wait_idle(1'b1, 80);
		iso_peer_inst.send_pair(1'b0, 1'b1);
		wait_idle(1'b0, 800);
		$display("slave role done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		{clk, rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{role, enable, mosi_drv, miso_drv, sck_drv, cs_drv} = 6'b111101;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		c = 0;
		do_reset(1'b1);
		t_master_pins();
		t_master_link();
		t_master_idle();
		t_slave();
		close_out();
	end
endmodule
`default_nettype wire
